// *** design/qbsram_map.svh ***
// constants for the two-beat byte-lane sram block
`ifndef QBSRAM_MAP_SVH
`define QBSRAM_MAP_SVH
`define QBSRAM_LANE_W 9
`define QBSRAM_BEAT0 1'b0
`define QBSRAM_BEAT1 1'b1
`define QBSRAM_ADDR_W 19
`define QBSRAM_LANES 4
`endif

// *** design/qbsram_pkg.sv ***
// types for the two-beat byte-lane sram block
package qbsram_pkg;
  typedef enum logic [1:0] {
    QBSRAM_IDLE = 2'b01,
    QBSRAM_BEAT2 = 2'b10
  } qbsram_state_t;
endpackage

// *** design/qbsram_core.sv ***
// two-beat burst sram core with byte-lane write masking
`timescale 1ns/1ps
`include "qbsram_map.svh"
module qbsram_core
  import qbsram_pkg::*;
#(
  parameter int ADDR_W = `QBSRAM_ADDR_W,
  parameter int LANES = `QBSRAM_LANES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic beat_phase,
  input wire logic [LANES*`QBSRAM_LANE_W-1:0] wr_data,
  input wire logic [LANES-1:0] lane_sel_n,
  output logic [LANES*`QBSRAM_LANE_W-1:0] rd_data,
  output logic rd_valid,
  output logic rd_oe_n
);
  localparam int DW = LANES * `QBSRAM_LANE_W;
  localparam int DEPTH = 2 ** (ADDR_W + 1);

  logic [DW-1:0] mem [DEPTH];

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] sel_n);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i*`QBSRAM_LANE_W +: `QBSRAM_LANE_W] = {`QBSRAM_LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction

  function automatic logic [ADDR_W:0] burst_addr(input logic [ADDR_W-1:0] a, input logic b);
    return {a, b};
  endfunction

  // ------------------------------------------------------------
  // write machine
  // ------------------------------------------------------------
  qbsram_state_t wr_state_reg;
  qbsram_state_t wr_state_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DW-1:0] wr_hold_data_reg;
  logic [LANES-1:0] wr_hold_sel_reg;
  logic wr_hold_beat_reg;
  logic wr_hold_vld_reg;
  logic [ADDR_W-1:0] wr_hold_addr_reg;

  // control is only looked at on true-clock edges
  wire wr_idle = wr_state_reg == QBSRAM_IDLE;
  wire wr_busy = wr_state_reg == QBSRAM_BEAT2;
  wire wr_start = !wr_sel_n && !beat_phase && wr_idle;
  wire wr_second = beat_phase && wr_busy;
  // selects outside a started burst never reach the array
  wire wr_take = wr_start || wr_second;
  wire wr_beat_now = wr_second ? `QBSRAM_BEAT1 : `QBSRAM_BEAT0;
  wire [ADDR_W-1:0] wr_addr_now = wr_start ? addr : wr_addr_reg;

  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      QBSRAM_IDLE: begin
        if (wr_start) begin
          wr_state_next = QBSRAM_BEAT2;
        end
      end
      QBSRAM_BEAT2: begin
        // no length setting: the second beat always closes the burst
        if (wr_second) begin
          wr_state_next = QBSRAM_IDLE;
        end
      end
      default: begin
        wr_state_next = QBSRAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_reg <= QBSRAM_IDLE;
      wr_addr_reg <= '0;
    end else begin
      wr_state_reg <= wr_state_next;
      if (wr_start) begin
        wr_addr_reg <= addr;
      end
    end
  end

  // per-beat holding stage, so each beat keeps its own lane selects
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_hold_data_reg <= '0;
      wr_hold_sel_reg <= '1;
      wr_hold_beat_reg <= `QBSRAM_BEAT0;
      wr_hold_vld_reg <= 1'b0;
    end else begin
      wr_hold_vld_reg <= wr_take;
      if (wr_take) begin
        wr_hold_data_reg <= wr_data;
        wr_hold_sel_reg <= lane_sel_n;
        wr_hold_beat_reg <= wr_beat_now;
      end
    end
  end

  // no reset needed: only used together with wr_hold_vld_reg
  always_ff @(posedge ref_clk) begin
    if (wr_take) begin
      wr_hold_addr_reg <= wr_addr_now;
    end
  end

  wire [ADDR_W:0] wr_ba = burst_addr(wr_hold_addr_reg, wr_hold_beat_reg);
  wire [DW-1:0] wr_mask = lane_mask(wr_hold_sel_reg);
  wire [DW-1:0] wr_keep = mem[wr_ba] & ~wr_mask;
  wire [DW-1:0] wr_new = wr_hold_data_reg & wr_mask;

  // ------------------------------------------------------------
  // array
  // ------------------------------------------------------------
  // no reset on the array: contents are undefined at power-up anyway
  // no forwarding: a read one cycle after a write still sees old data
  always_ff @(posedge ref_clk) begin
    if (wr_hold_vld_reg) begin
      mem[wr_ba] <= wr_keep | wr_new;
    end
  end

  // ------------------------------------------------------------
  // read machine
  // ------------------------------------------------------------
  qbsram_state_t rd_state_reg;
  qbsram_state_t rd_state_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [DW-1:0] rd_data_reg;
  logic rd_valid_reg;
  logic rd_oe_n_reg;

  wire rd_idle = rd_state_reg == QBSRAM_IDLE;
  wire rd_busy = rd_state_reg == QBSRAM_BEAT2;
  wire rd_start = !rd_sel_n && !beat_phase && rd_idle;
  wire rd_second = beat_phase && rd_busy;
  wire rd_take = rd_start || rd_second;
  wire nop = rd_sel_n && wr_sel_n && !beat_phase;
  // first beat reads straight from the pins, second from the held address
  wire [ADDR_W-1:0] rd_base = rd_start ? addr : rd_addr_reg;
  wire rd_beat = rd_start ? `QBSRAM_BEAT0 : `QBSRAM_BEAT1;
  wire [ADDR_W:0] rd_ba = burst_addr(rd_base, rd_beat);

  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      QBSRAM_IDLE: begin
        if (rd_start) begin
          rd_state_next = QBSRAM_BEAT2;
        end
      end
      QBSRAM_BEAT2: begin
        if (rd_second) begin
          rd_state_next = QBSRAM_IDLE;
        end
      end
      default: begin
        rd_state_next = QBSRAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_reg <= QBSRAM_IDLE;
      rd_addr_reg <= '0;
    end else begin
      rd_state_reg <= rd_state_next;
      if (rd_start) begin
        rd_addr_reg <= addr;
      end
    end
  end

  // output stage: data holds between beats, drive stays on until a nop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_oe_n_reg <= 1'b1;
    end else begin
      rd_valid_reg <= rd_take;
      if (rd_take) begin
        rd_data_reg <= mem[rd_ba];
        rd_oe_n_reg <= 1'b0;
      end else if (nop) begin
        rd_oe_n_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_oe_n = rd_oe_n_reg;
endmodule

// *** tb/qbsram_checker.sv ***
// port assertions for the sram core
`timescale 1ns/1ps
module qbsram_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic beat_phase,
  input wire logic [35:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_oe_n
);
  logic go_reg, nop_reg;
  wire go = !beat_phase && !rd_sel_n;
  wire nop = !beat_phase && rd_sel_n && wr_sel_n;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) {go_reg, nop_reg} <= 2'h0;
    else {go_reg, nop_reg} <= {go, nop};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence two_beats;
    rd_valid && !rd_oe_n ##1 rd_valid && !rd_oe_n;
  endsequence
  chk_read_beats: assert property (go |=> two_beats) else $error("read beats late");
  chk_valid_cause: assert property (rd_valid |-> go_reg || $past(go_reg))
    else $error("stray read beat");
  chk_burst_end: assert property (nop || !beat_phase && rd_sel_n |=> !rd_valid [*2])
    else $error("extra read beat");
  chk_nop_float: assert property (nop |-> ##[1:2] rd_oe_n) else $error("output not off");
  chk_oe_hold: assert property (!rd_oe_n && !nop && !nop_reg |=> !rd_oe_n)
    else $error("output dropped early");
  chk_valid_oe: assert property (rd_valid |-> !rd_oe_n) else $error("beat while off");
  chk_data_hold: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
  chk_reset_quiet: assert property ($rose(rst_n) |-> rd_oe_n && !rd_valid)
    else $error("busy after reset");
endmodule
bind qbsram_core qbsram_checker i_chk (.ref_clk, .rst_n, .rd_sel_n, .wr_sel_n, .beat_phase,
  .rd_data, .rd_valid, .rd_oe_n);

// *** tb/qbsram_ctrl_model.sv ***
// controller model issuing two-beat bursts
`timescale 1ns/1ps
module qbsram_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic [18:0] addr,
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic beat_phase,
  output logic [35:0] wr_data,
  output logic [3:0] lane_sel_n,
  input wire logic [35:0] rd_data
);
  // selects idle high so nothing starts while reset is released
  initial begin
    {addr, beat_phase, wr_data} = '0;
    {rd_sel_n, wr_sel_n, lane_sel_n} = '1;
  end
  always @(posedge ref_clk) beat_phase <= #1 ~beat_phase;
  task automatic burst(input logic w, r, input logic [18:0] a, input logic [35:0] d0,
      input logic [3:0] s0, input logic [35:0] d1, input logic [3:0] s1,
      output logic [35:0] q0, q1);
    do @(posedge ref_clk); while (beat_phase !== 1'b1);
    #1 {wr_sel_n, rd_sel_n, addr, wr_data, lane_sel_n} = {~w, ~r, a, d0, s0};
    @(posedge ref_clk);
    #1 q0 = rd_data;
    {wr_sel_n, rd_sel_n, wr_data, lane_sel_n} = {2'h3, d1, s1};
    @(posedge ref_clk);
    #1 q1 = rd_data;
    // released lines show the inverse, not a stale copy
    {addr, wr_data, lane_sel_n} = {~addr, ~wr_data, ~lane_sel_n};
  endtask
endmodule

// *** tb/test_qbsram_core.sv ***
// self-checking bench for the sram core
`timescale 1ns/1ps
module test_qbsram_core;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_sel_n, wr_sel_n, beat_phase, rd_valid, rd_oe_n;
  logic [18:0] addr;
  logic [35:0] wr_data, rd_data;
  logic [3:0] lane_sel_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  qbsram_core i_dut (.ref_clk, .rst_n, .addr, .rd_sel_n, .wr_sel_n, .beat_phase, .wr_data,
    .lane_sel_n, .rd_data, .rd_valid, .rd_oe_n);
  qbsram_ctrl_model i_ctl (.ref_clk, .rst_n, .addr, .rd_sel_n, .wr_sel_n, .beat_phase,
    .wr_data, .lane_sel_n, .rd_data);
  function automatic logic [35:0] lm(input logic [3:0] s);
    for (int i = 0; i < 4; i++) lm[9*i+:9] = {9{~s[i]}};
  endfunction
  task automatic cmp(input string nm, input logic [35:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_lanes();
    logic [3:0] s0, s1;
    logic [35:0] q0, q1, z;
    z = 36'h0;
    for (int i = 0; i < 5; i++) begin
      s0 = ~(4'h1 << i);
      s1 = {s0[0], s0[3:1]};
      i_ctl.burst(1'b1, 1'b0, 19'(i + 1), ~z, 4'h0, ~z, 4'h0, q0, q1);
      i_ctl.burst(1'b1, 1'b0, 19'(i + 1), z, s0, z, s1, q0, q1);
      i_ctl.burst(1'b0, 1'b0, 19'(i + 1), z, 4'h0, z, 4'h0, q0, q1);
      cmp("output off", 36'h1, {35'h0, rd_oe_n});
      i_ctl.burst(1'b0, 1'b1, 19'(i + 1), z, 4'h0, z, 4'h0, q0, q1);
      cmp("lane beat0", ~lm(s0), q0);
      cmp("lane beat1", ~lm(s1), q1);
    end
    $display("lane test done");
  endtask
  task automatic t_concur();
    logic [35:0] q0, q1;
    i_ctl.burst(1'b1, 1'b1, 19'h1, 36'h123456789, 4'h0, 36'h0abcdef01, 4'h0, q0, q1);
    cmp("old beat0", ~lm(4'he), q0);
    cmp("old beat1", ~lm(4'h7), q1);
    i_ctl.burst(1'b0, 1'b1, 19'h1, 36'h0, 4'hf, 36'h0, 4'hf, q0, q1);
    cmp("new beat0", 36'h123456789, q0);
    cmp("new beat1", 36'h0abcdef01, q1);
    $display("concurrent test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_lanes();
    t_concur();
    test_done();
  end
  initial begin
    #5000;
    n_mismatch++;
    test_done();
  end
endmodule
